/* hw/mfsb_pkg.sv */
// Constants, field layout and state type of the module flag status bank.
package mfsb_pkg;

   // ----------------------------------------------------------------
   // Address map of the lower page region served by this bank
   // ----------------------------------------------------------------
   localparam int            ADDR_W                     = 7;
   localparam logic [6:0]    ADDR_STATUS_RESERVED       = 7'h01;
   localparam logic [6:0]    ADDR_MODULE_STATUS         = 7'h02;
   localparam logic [6:0]    ADDR_LOS_FLAGS             = 7'h03;
   localparam logic [6:0]    ADDR_TX_FAULT_FLAGS        = 7'h04;
   localparam logic [6:0]    ADDR_CHANNEL_STATUS_RSVD   = 7'h05;
   localparam logic [6:0]    ADDR_TEMPERATURE_FLAGS     = 7'h06;
   localparam logic [6:0]    ADDR_SUPPLY_VOLTAGE_FLAGS  = 7'h07;
   localparam logic [6:0]    ADDR_MODULE_FLAGS_RSVD     = 7'h08;
   localparam logic [6:0]    ADDR_RX_POWER_FLAGS_CH12   = 7'h09;
   localparam logic [6:0]    ADDR_RX_POWER_FLAGS_CH34   = 7'h0A;
   localparam logic [6:0]    ADDR_TX_BIAS_FLAGS_CH12    = 7'h0B;
   localparam logic [6:0]    ADDR_TX_BIAS_FLAGS_CH34    = 7'h0C;
   localparam logic [6:0]    ADDR_TX_POWER_FLAGS_CH12   = 7'h0D;
   localparam logic [6:0]    ADDR_TX_POWER_FLAGS_CH34   = 7'h0E;
   localparam logic [6:0]    ADDR_MON_FLAGS_SET4_RSVD   = 7'h0F;
   localparam logic [6:0]    ADDR_MON_FLAGS_SET5_RSVD   = 7'h11;
   localparam logic [6:0]    ADDR_MON_FLAGS_SET6_RSVD   = 7'h13;
   localparam logic [6:0]    ADDR_FLAG_FIELD_TAIL_RSVD  = 7'h15;

   // The implemented flag bytes run from the first flag byte upward.
   localparam logic [6:0]    ADDR_FLAG_FIRST            = 7'h03;
   localparam logic [6:0]    ADDR_FLAG_LAST             = 7'h15;
   localparam int            FLAG_BYTES                 = 12;

   // ----------------------------------------------------------------
   // Field positions in the module status byte
   // ----------------------------------------------------------------
   localparam int            STATUS_INT_PIN_BIT         = 1;
   localparam int            STATUS_DATA_NOT_READY_BIT  = 0;

   // ----------------------------------------------------------------
   // Implemented bits per flag byte, index 0 is the first flag byte
   // ----------------------------------------------------------------
   localparam logic [11:0][7:0] FLAG_IMPL_MASK = {
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'h00, 8'hF0, 8'hF0, 8'h00, 8'h0F, 8'h0F
   };

   // ----------------------------------------------------------------
   // State of the bank
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [11:0][7:0] fb;        // Latched flag bytes 3 to 14.
      logic             dnr;       // Monitor data not ready.
      logic             irq;       // Any latched flag set.
      logic [7:0]       rd_data;   // Byte returned to the engine.
      logic             rd_valid;  // Read data strobe.
      logic             mrst_meta; // Module reset pin, first stage.
      logic             mrst_sync; // Module reset pin, second stage.
   } mfsb_state_type;

   localparam logic             RESET_DNR      = 1'b1;
   localparam logic [7:0]       RESET_RD_DATA  = 8'h00;
   localparam mfsb_state_type   STATE_RESET    = '{
      fb:        '0,
      dnr:       RESET_DNR,
      irq:       1'b0,
      rd_data:   RESET_RD_DATA,
      rd_valid:  1'b0,
      mrst_meta: 1'b0,
      mrst_sync: 1'b0
   };

endpackage

/* hw/mfsb_flag_bank.sv */
// Status and latched flag bank of a four channel transceiver module.
`timescale 1ns/10ps

module mfsb_flag_bank
   import mfsb_pkg::*;
(
   input  wire logic        clk,                    // 100 MHz clock.
   input  wire logic        resetn,                 // Async reset, low.
   input  wire logic        ce,                     // Clock enable.
   input  wire logic        module_reset_n,         // Module reset pin.
   input  wire logic        rd_en,                  // Byte read strobe.
   input  wire logic [6:0]  rd_addr,                // Byte address.
   output logic       [7:0] rd_data,                // Byte read back.
   output logic             rd_valid,               // Read data strobe.
   input  wire logic        monitor_data_ready,     // Monitors valid.
   input  wire logic [3:0]  rx_signal_loss,         // Rx loss, ch4..1.
   input  wire logic [3:0]  tx_fault,               // Tx fault, ch4..1.
   input  wire logic [3:0]  temperature_cond,       // HA,LA,HW,LW.
   input  wire logic [3:0]  supply_voltage_cond,    // HA,LA,HW,LW.
   input  wire logic [15:0] rx_power_cond,          // Ch1 nibble on top.
   input  wire logic [15:0] tx_bias_cond,           // Ch1 nibble on top.
   input  wire logic [15:0] tx_power_cond,          // Ch1 nibble on top.
   output logic             module_interrupt_out_n  // Interrupt, low.
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic in_flag_bytes(input logic [6:0] a);
      in_flag_bytes = (a >= ADDR_FLAG_FIRST) &&
                      (a <= ADDR_TX_POWER_FLAGS_CH34);
   endfunction

   function automatic logic [3:0] flag_index(input logic [6:0] a);
      logic [6:0] diff;
      diff = a - ADDR_FLAG_FIRST;
      flag_index = diff[3:0];
   endfunction

   // Reserved bytes and addresses outside the bank read as zero.
   function automatic logic [7:0] read_byte(input mfsb_state_type s,
                                            input logic [6:0]    a);
      logic [7:0] b;
      b = 8'h00;
      if (a == ADDR_MODULE_STATUS) begin
         b[STATUS_INT_PIN_BIT]        = ~s.irq;
         b[STATUS_DATA_NOT_READY_BIT] = s.dnr;
      end else if (in_flag_bytes(a)) begin
         b = s.fb[flag_index(a)] & FLAG_IMPL_MASK[flag_index(a)];
      end
      read_byte = b;
   endfunction

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else if (ce) begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Flag latching and read clearing
   // ----------------------------------------------------------------
   mfsb_state_type q;
   mfsb_state_type d;

   always_comb begin
      logic [11:0][7:0] set_v;
      logic [11:0][7:0] clr_v;
      set_v = '0;
      clr_v = '0;
      d     = q;

      // The pin is asynchronous to clk, so only the second stage is used.
      d.mrst_meta = module_reset_n;
      d.mrst_sync = q.mrst_meta;

      set_v[0]  = {4'h0, rx_signal_loss};
      set_v[1]  = {4'h0, tx_fault};
      set_v[3]  = {temperature_cond, 4'h0};
      set_v[4]  = {supply_voltage_cond, 4'h0};
      set_v[6]  = rx_power_cond[15:8];
      set_v[7]  = rx_power_cond[7:0];
      set_v[8]  = tx_bias_cond[15:8];
      set_v[9]  = tx_bias_cond[7:0];
      set_v[10] = tx_power_cond[15:8];
      set_v[11] = tx_power_cond[7:0];

      // A read clears only the byte it covers, after the value is taken.
      if (rd_en && in_flag_bytes(rd_addr)) begin
         clr_v[flag_index(rd_addr)] = 8'hFF;
      end

      for (int i = 0; i < FLAG_BYTES; i++) begin
         // A condition present during the clearing read keeps its flag.
         d.fb[i] = ((q.fb[i] & ~clr_v[i]) | set_v[i])
                   & FLAG_IMPL_MASK[i];
      end

      // Module reset dominates, even over a live condition.
      if (!q.mrst_sync) begin
         d.fb = '0;
      end

      if (monitor_data_ready) begin
         d.dnr = 1'b0;
      end

      d.irq      = |d.fb;
      d.rd_valid = rd_en;
      if (rd_en) begin
         d.rd_data = read_byte(q, rd_addr);
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q <= STATE_RESET;
      end else if (ce) begin
         q <= d;
      end
   end

   assign rd_data                = q.rd_data;
   assign rd_valid               = q.rd_valid;
   assign module_interrupt_out_n = ~q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_q);

   a_int_pin_level: assert property (
      module_interrupt_out_n == !(|q.fb))
      else $error("interrupt pin does not follow latched flags");

   a_status_int_bit: assert property (
      ce && rd_en && rd_addr == ADDR_MODULE_STATUS
      |=> rd_data[STATUS_INT_PIN_BIT] == $past(module_interrupt_out_n)
          && rd_data[7:2] == 6'h00 && rd_valid)
      else $error("status byte does not show interrupt pin");

   a_data_ready_clear: assert property (
      ce && monitor_data_ready |=> !q.dnr)
      else $error("not ready bit stays set after data ready");

   a_los_set_latch: assert property (
      ce && rx_signal_loss[0] && q.mrst_sync |=> q.fb[0][0])
      else $error("receive loss flag not latched");

   a_los_held: assert property (
      ce && q.fb[0][0] && q.mrst_sync &&
      !(rd_en && rd_addr == ADDR_LOS_FLAGS) |=> q.fb[0][0])
      else $error("latched flag lost without a read");

   a_read_clears: assert property (
      ce && rd_en && rd_addr == ADDR_LOS_FLAGS && q.mrst_sync &&
      rx_signal_loss == 4'h0 |=> q.fb[0] == 8'h00)
      else $error("read of flag byte did not clear it");

   a_tx_los_zero: assert property (
      ce && rd_en && rd_addr == ADDR_LOS_FLAGS |=> rd_data[7:4] == 4'h0)
      else $error("transmit input loss bits read as set");

   a_reserved_zero: assert property (
      ce && rd_en && (rd_addr == ADDR_STATUS_RESERVED ||
      rd_addr == ADDR_CHANNEL_STATUS_RSVD ||
      rd_addr == ADDR_MODULE_FLAGS_RSVD ||
      (rd_addr >= ADDR_MON_FLAGS_SET4_RSVD &&
       rd_addr <= ADDR_FLAG_LAST)) |=> rd_data == 8'h00)
      else $error("reserved byte reads non zero");

   a_module_reset_clear: assert property (
      ce && !q.mrst_sync |=> q.fb == '0 && module_interrupt_out_n)
      else $error("module reset did not clear flags");

   a_rx_power_read: assert property (
      ce && rd_en && rd_addr == ADDR_RX_POWER_FLAGS_CH12
      |=> rd_data == $past(q.fb[6]))
      else $error("receive power byte read back wrong");

   // ----------------------------------------------------------------
   // Checks on flag setting, clearing and reserved bits
   // ----------------------------------------------------------------
   a_los_all_set: assert property (
      ce && q.mrst_sync
      |=> (q.fb[0][3:0] & $past(rx_signal_loss))
          == $past(rx_signal_loss))
      else $error("receive loss condition not latched");

   a_fault_all_set: assert property (
      ce && q.mrst_sync
      |=> (q.fb[1][3:0] & $past(tx_fault)) == $past(tx_fault))
      else $error("transmit fault condition not latched");

   a_temp_all_set: assert property (
      ce && q.mrst_sync
      |=> (q.fb[3][7:4] & $past(temperature_cond))
          == $past(temperature_cond))
      else $error("temperature condition not latched");

   a_supply_all_set: assert property (
      ce && q.mrst_sync
      |=> (q.fb[4][7:4] & $past(supply_voltage_cond))
          == $past(supply_voltage_cond))
      else $error("supply condition not latched");

   a_rx_power_set: assert property (
      ce && q.mrst_sync
      |=> ({q.fb[6], q.fb[7]} & $past(rx_power_cond))
          == $past(rx_power_cond))
      else $error("receive power condition not latched");

   a_tx_bias_set: assert property (
      ce && q.mrst_sync
      |=> ({q.fb[8], q.fb[9]} & $past(tx_bias_cond))
          == $past(tx_bias_cond))
      else $error("transmit bias condition not latched");

   a_tx_power_set: assert property (
      ce && q.mrst_sync
      |=> ({q.fb[10], q.fb[11]} & $past(tx_power_cond))
          == $past(tx_power_cond))
      else $error("transmit power condition not latched");

   a_tx_los_never: assert property (
      q.fb[0][7:4] == 4'h0)
      else $error("transmit input loss flag set");

   a_fault_rsvd_zero: assert property (
      q.fb[1][7:4] == 4'h0 && q.fb[2] == 8'h00)
      else $error("reserved fault bits set");

   a_temp_rsvd_zero: assert property (
      q.fb[3][3:0] == 4'h0)
      else $error("reserved temperature bits set");

   a_supply_rsvd_zero: assert property (
      q.fb[4][3:0] == 4'h0 && q.fb[5] == 8'h00)
      else $error("reserved supply bits set");

   // A flag may only rise where its condition was present.
   a_no_false_los: assert property (
      ce |=> (q.fb[0] & ~$past(q.fb[0])
              & ~{4'h0, $past(rx_signal_loss)}) == 8'h00)
      else $error("receive loss flag rose without condition");

   a_no_false_temp: assert property (
      ce |=> (q.fb[3] & ~$past(q.fb[3])
              & ~{$past(temperature_cond), 4'h0}) == 8'h00)
      else $error("temperature flag rose without condition");

   a_no_false_power: assert property (
      ce |=> ({q.fb[6], q.fb[7]} & ~$past({q.fb[6], q.fb[7]})
              & ~$past(rx_power_cond)) == 16'h0000)
      else $error("receive power flag rose without condition");

   a_irq_on_flag: assert property (
      ce && q.mrst_sync && (|tx_fault) |=> !module_interrupt_out_n)
      else $error("interrupt not asserted for a new flag");

   a_mreset_blocks: assert property (
      ce && !q.mrst_sync && (|tx_fault) |=> module_interrupt_out_n)
      else $error("condition latched during module reset");

   a_other_bytes_kept: assert property (
      ce && rd_en && rd_addr == ADDR_LOS_FLAGS && q.mrst_sync
      |=> ($past(q.fb[11:1]) & ~q.fb[11:1]) == '0)
      else $error("read of one byte cleared another byte");

   a_temp_read_clears: assert property (
      ce && rd_en && rd_addr == ADDR_TEMPERATURE_FLAGS && q.mrst_sync
      && temperature_cond == 4'h0 |=> q.fb[3] == 8'h00)
      else $error("read of temperature flags did not clear them");

   a_set_beats_clear: assert property (
      ce && rd_en && rd_addr == ADDR_LOS_FLAGS && q.mrst_sync
      && rx_signal_loss[1] |=> q.fb[0][1])
      else $error("live condition lost to a clearing read");

   a_ce_freeze: assert property (
      !ce |=> $stable(q))
      else $error("state changed while clock enable low");

   // ----------------------------------------------------------------
   // Checks on the read port and the status byte
   // ----------------------------------------------------------------
   a_read_valid_pulse: assert property (
      ce && rd_en |=> rd_valid)
      else $error("read not answered on the next edge");

   a_valid_idle_low: assert property (
      ce && !rd_en |=> !rd_valid)
      else $error("read strobe without a read");

   a_read_data_holds: assert property (
      !(ce && rd_en) |=> $stable(rd_data))
      else $error("read data changed without a read");

   a_status_no_clear: assert property (
      ce && rd_en && q.mrst_sync && (rd_addr < ADDR_LOS_FLAGS ||
      rd_addr > ADDR_TX_POWER_FLAGS_CH34)
      |=> ($past(q.fb) & ~q.fb) == '0)
      else $error("read outside flag bytes cleared a flag");

   a_field_span_only: assert property (
      ce && rd_en && (rd_addr < ADDR_STATUS_RESERVED ||
      rd_addr > ADDR_FLAG_LAST) |=> rd_data == 8'h00)
      else $error("byte outside the bank reads non zero");

   a_dnr_held: assert property (
      ce && q.dnr && !monitor_data_ready |=> q.dnr)
      else $error("not ready bit cleared before data ready");

   a_dnr_sticky: assert property (
      !q.dnr |=> !q.dnr)
      else $error("not ready bit set again");

   a_status_dnr_bit: assert property (
      ce && rd_en && rd_addr == ADDR_MODULE_STATUS
      |=> rd_data[STATUS_DATA_NOT_READY_BIT] == $past(q.dnr))
      else $error("status byte does not show not ready bit");

   a_fault_read_back: assert property (
      ce && rd_en && rd_addr == ADDR_TX_FAULT_FLAGS
      |=> rd_data == {4'h0, $past(q.fb[1][3:0])})
      else $error("transmit fault byte read back wrong");

   a_supply_read_back: assert property (
      ce && rd_en && rd_addr == ADDR_SUPPLY_VOLTAGE_FLAGS
      |=> rd_data == {$past(q.fb[4][7:4]), 4'h0})
      else $error("supply flag byte read back wrong");

   a_bias_read_back: assert property (
      ce && rd_en && rd_addr == ADDR_TX_BIAS_FLAGS_CH34
      |=> rd_data == $past(q.fb[9]))
      else $error("transmit bias byte read back wrong");

   a_txpwr_read_back: assert property (
      ce && rd_en && rd_addr == ADDR_TX_POWER_FLAGS_CH12
      |=> rd_data == $past(q.fb[10]))
      else $error("transmit power byte read back wrong");

endmodule

/* sim/mfsb_host_model.sv */
// Host side model that fetches status and flag bytes one at a time.
`timescale 1ns/10ps

module mfsb_host_model (
   input  wire logic       clk,      // Bank clock.
   output logic            rd_en,    // Byte read strobe.
   output logic      [6:0] rd_addr,  // Byte address.
   input  wire logic [7:0] rd_data,  // Byte read back.
   input  wire logic       rd_valid  // Read data strobe.
);
   initial begin
      rd_en   = 1'b0;
      rd_addr = 7'h7F;
   end

   // One strobe per byte, so a sequential read is a run of single fetches.
   task automatic rd(input logic [6:0] a, output logic [7:0] d,
                     output logic ok);
      ok = 1'b0;
      d  = 8'h00;
      @(negedge clk);
      rd_en   = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_en   = 1'b0;
      // The idle address flips so a stale value can never look valid.
      rd_addr = ~a;
      for (int i = 0; i < 4; i++) begin
         if (rd_valid === 1'b1) begin
            d  = rd_data;
            ok = 1'b1;
            break;
         end
         @(negedge clk);
      end
   endtask
endmodule

/* sim/tb.sv */
// Self-checking testbench of the module flag status bank.
`timescale 1ns/10ps

module tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ce = 1'b1;
   logic        module_reset_n = 1'b1;
   logic        mdr = 1'b0;
   logic [3:0]  rx_sl = 4'h0;
   logic [3:0]  tx_flt = 4'h0;
   logic [3:0]  temp_c = 4'h0;
   logic [3:0]  volt_c = 4'h0;
   logic [15:0] rxp_c = 16'h0000;
   logic [15:0] bias_c = 16'h0000;
   logic [15:0] txp_c = 16'h0000;
   logic        rd_en;
   logic [6:0]  rd_addr;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        int_n;
   logic [7:0]  e [0:22];
   logic [7:0]  got;
   logic        ok;
   int          n_mismatch = 0;
   int          n_tests = 0;

   always #5 clk = ~clk;

   mfsb_flag_bank u_dut (
      .clk                    (clk),
      .resetn                 (resetn),
      .ce                     (ce),
      .module_reset_n         (module_reset_n),
      .rd_en                  (rd_en),
      .rd_addr                (rd_addr),
      .rd_data                (rd_data),
      .rd_valid               (rd_valid),
      .monitor_data_ready     (mdr),
      .rx_signal_loss         (rx_sl),
      .tx_fault               (tx_flt),
      .temperature_cond       (temp_c),
      .supply_voltage_cond    (volt_c),
      .rx_power_cond          (rxp_c),
      .tx_bias_cond           (bias_c),
      .tx_power_cond          (txp_c),
      .module_interrupt_out_n (int_n)
   );

   mfsb_host_model u_host (
      .clk      (clk),
      .rd_en    (rd_en),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .rd_valid (rd_valid)
   );

   task automatic end_sim();
      $display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      n_tests++;
      if (g !== x) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask

   // Reads bytes 0 to 22 in order and compares each against the table.
   task automatic sweep();
      for (int a = 0; a < 23; a++) begin
         u_host.rd(a[6:0], got, ok);
         if (ok !== 1'b1) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
            end_sim();
         end
         chk(got, e[a]);
      end
   endtask

   // Distinct patterns per input so a swapped nibble or bit shows up.
   task automatic setc(input logic on);
      @(negedge clk);
      rx_sl  = on ? 4'h9 : 4'h0;
      tx_flt = on ? 4'h6 : 4'h0;
      temp_c = on ? 4'h8 : 4'h0;
      volt_c = on ? 4'h1 : 4'h0;
      rxp_c  = on ? 16'h8421 : 16'h0000;
      bias_c = on ? 16'h1248 : 16'h0000;
      txp_c  = on ? 16'hC35A : 16'h0000;
   endtask

   initial begin
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      e = '{default: 8'h00};
      e[2] = 8'h03;
      sweep();
      chk({7'h00, int_n}, 8'h01);
      $display("Test reset values done");
      mdr = 1'b1;
      setc(1'b1);
      setc(1'b0);
      chk({7'h00, int_n}, 8'h00);
      e[2] = 8'h00;
      e[3] = 8'h09;
      e[4] = 8'h06;
      e[6] = 8'h80;
      e[7] = 8'h10;
      e[9] = 8'h84;
      e[10] = 8'h21;
      e[11] = 8'h12;
      e[12] = 8'h48;
      e[13] = 8'hC3;
      e[14] = 8'h5A;
      sweep();
      chk({7'h00, int_n}, 8'h01);
      e = '{default: 8'h00};
      e[2] = 8'h02;
      sweep();
      $display("Test latch and read clear done");
      // Conditions seen only while the clock enable is low must not latch.
      ce = 1'b0;
      setc(1'b1);
      repeat (3) @(negedge clk);
      setc(1'b0);
      ce = 1'b1;
      chk({7'h00, int_n}, 8'h01);
      $display("Test clock enable hold done");
      setc(1'b1);
      module_reset_n = 1'b0;
      repeat (5) @(negedge clk);
      chk({7'h00, int_n}, 8'h01);
      setc(1'b0);
      module_reset_n = 1'b1;
      repeat (4) @(negedge clk);
      sweep();
      chk({7'h00, int_n}, 8'h01);
      $display("Test module reset done");
      end_sim();
   end
endmodule
